// ===== logic/oscillator_switch_status.sv
// Our own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/10ps
`include "osc_switch_map.svh"

// Function
// - Current source code reads read-only in bits 6 to 4 of current selection.
// - Current divider code reads read-only in bits 3 to 0 of current selection.
// - Any reset makes current source and divider equal the requested ones.
// - Source codes decode to the listed oscillators; 101 and 010 reserved.
// - Divider code n divides by two to the n; codes above 1001 reserved.
// - Both external source codes run the external oscillator in the fuse mode.
// - Hold bit suspends the switch with interrupt; read/write, hardware clearable.
// - With hold clear when new source becomes ready, the switch is carried out.
// - Without bypass the power bit picks high or low power; bypass ignores it.
// - Bypass makes the input pin a Schmitt clock input; otherwise a crystal.
// - Switch done reads one when requested equals current and clock switched.
// - New source ready reads in bit 3 of the switch control register.
// - Ready flags show each oscillator usable, at their fixed positions.
// - Multiplier locked reads one only when PLL enabled, input ready and locked.
// - Unimplemented bits of all three registers always read zero.
// - New source ready and interrupt flag set together; interrupt if enabled.
// - On switch, current fields update, done sets, new source ready clears.
// - A reserved requested source code selects the fast internal oscillator.
module oscillator_switch_status
  import osc_switch_pkg::*;
(
  input wire logic clk_sys, // System clock, 250 MHz.
  input wire logic reset, // Asynchronous reset, active high.
  input wire logic [3:0] address, // Avalon byte address.
  input wire logic read, // Avalon read request.
  input wire logic write, // Avalon write request.
  input wire logic [3:0] byteenable, // Avalon byte enables.
  input wire logic [31:0] writedata, // Avalon write data.
  output logic [31:0] readdata, // Avalon read data.
  output logic waitrequest, // Avalon wait request.
  input wire logic [2:0] requested_source_sel, // Requested source code.
  input wire logic [3:0] requested_divider_sel, // Requested divider code.
  input wire osc_ready_t osc_ready, // Oscillator ready and PLL levels.
  input wire logic [7:0] src_tick, // Source ticks, indexed by source code.
  input wire logic [2:0] ext_osc_mode_fuse, // External oscillator mode fuse.
  input wire logic switch_irq_enable, // Clock switch interrupt enable.
  output osc_drive_t osc_drive, // Oscillator drive settings.
  output logic [2:0] current_source_sel, // Active source code.
  output logic [3:0] current_divider_sel, // Active divider code.
  output logic switch_done, // No switch in progress.
  output logic new_source_ready, // Requested oscillator ready.
  output logic switch_irq_flag, // Pulse that sets the switch interrupt flag.
  output logic switch_irq, // Switch interrupt request.
  output logic sys_clk_tick // One pulse per system clock period.
);

  // ==========================================================================
  // Decoding helpers
  function automatic logic is_reserved_src(input logic [2:0] code);
    is_reserved_src = (code == `OSC_SRC_RSVD_HI) || (code == `OSC_SRC_RSVD_LO);
  endfunction : is_reserved_src

  function automatic logic [2:0] effective_src(input logic [2:0] code);
    effective_src = is_reserved_src(code) ? `OSC_SRC_FAST : code;
  endfunction : effective_src

  function automatic logic uses_ext(input logic [2:0] code);
    uses_ext = (code == `OSC_SRC_EXT) || (code == `OSC_SRC_EXT_PLL);
  endfunction : uses_ext

  function automatic logic uses_pll(input logic [2:0] code);
    uses_pll = (code == `OSC_SRC_EXT_PLL) || (code == `OSC_SRC_FAST_PLL);
  endfunction : uses_pll

  function automatic logic source_ready(input logic [2:0] code, input osc_ready_t r, input logic locked);
    case (code)
      `OSC_SRC_EXT: source_ready = r.ext;
      `OSC_SRC_FAST: source_ready = r.fast;
      `OSC_SRC_SLOW: source_ready = r.slow;
      `OSC_SRC_SEC: source_ready = r.secondary;
      `OSC_SRC_EXT_PLL: source_ready = locked;
      `OSC_SRC_FAST_PLL: source_ready = locked;
      default: source_ready = r.fast;
    endcase
  endfunction : source_ready

  // ==========================================================================
  // State
  sw_state_t state_reg;
  sw_state_t state_next;
  logic [2:0] cur_src_reg;
  logic [2:0] cur_src_next;
  logic [3:0] cur_div_reg;
  logic [3:0] cur_div_next;
  logic nsr_reg;
  logic nsr_next;
  logic hold_reg;
  logic hold_next;
  logic power_reg;
  logic power_next;
  logic bypass_reg;
  logic bypass_next;
  logic init_reg;
  logic irq_reg;
  logic irq_next;
  osc_drive_t drive_reg;
  osc_drive_t drive_next;
  localparam logic [7:0] ctrl_rst_value = `OSC_RST_CTRL;
  logic restart;
  logic at_boundary;
  logic [2:0] req_src;
  logic mismatch;
  logic pll_locked;
  logic [2:0] pll_base;

  assign req_src = effective_src(requested_source_sel);
  assign mismatch = (req_src != cur_src_reg) || (requested_divider_sel != cur_div_reg);
  // The PLL input follows the request once a PLL code is requested, else the current one.
  assign pll_base = uses_pll(req_src) ? req_src : cur_src_reg;
  assign pll_locked = osc_ready.pll_lock && osc_ready.pll_enable
                      && (uses_ext(pll_base) ? osc_ready.ext : osc_ready.fast);

  // ==========================================================================
  // Avalon-MM slave: one wait cycle per access, writes land when waitrequest is low
  logic ack_reg;
  logic ack_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic ctrl_write;

  assign waitrequest = (read || write) && !ack_reg;
  assign ctrl_write = write && ack_reg && (address == `OSC_OFS_SWITCH_CTRL) && byteenable[0];

  always_comb
  begin
    ack_next = (read || write) && !ack_reg;
    rdata_next = rdata_reg;
    if (read && !ack_reg)
    begin
      case (address)
        `OSC_OFS_CURRENT_SEL: rdata_next = {24'h000000, 1'b0, cur_src_reg, cur_div_reg};
        `OSC_OFS_SWITCH_CTRL: rdata_next = {24'h000000, hold_reg, power_reg, bypass_reg,
                                            switch_done, nsr_reg, 3'h0};
        `OSC_OFS_READY_STAT: rdata_next = {24'h000000, osc_ready.ext, osc_ready.fast, 1'b0,
                                           osc_ready.slow, osc_ready.secondary,
                                           osc_ready.converter_rc, 1'b0, pll_locked};
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end
    else
    begin
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  assign readdata = rdata_reg;

  // ==========================================================================
  // Switch sequencer
  always_comb
  begin
    state_next = state_reg;
    cur_src_next = cur_src_reg;
    cur_div_next = cur_div_reg;
    nsr_next = nsr_reg;
    hold_next = hold_reg;
    power_next = power_reg;
    bypass_next = bypass_reg;
    irq_next = 1'b0;
    restart = 1'b0;
    if (init_reg)
    begin
      // Reset cannot load a port value, so the request is copied at the first edge after release.
      cur_src_next = req_src;
      cur_div_next = requested_divider_sel;
      restart = 1'b1;
      state_next = SW_IDLE;
    end
    else
    begin
      case (state_reg)
        SW_IDLE:
        begin
          if (mismatch)
            state_next = SW_WAIT_READY;
        end
        SW_WAIT_READY:
        begin
          if (!mismatch)
            state_next = SW_IDLE;
          else if (source_ready(req_src, osc_ready, pll_locked))
          begin
            nsr_next = 1'b1;
            irq_next = 1'b1;
            state_next = hold_reg ? SW_HELD : SW_SWITCH;
          end
        end
        SW_HELD:
        begin
          if (!mismatch)
          begin
            // Abandoned by software: the hold is released by hardware.
            nsr_next = 1'b0;
            hold_next = 1'b0;
            state_next = SW_IDLE;
          end
          else if (!source_ready(req_src, osc_ready, pll_locked))
          begin
            nsr_next = 1'b0;
            state_next = SW_WAIT_READY;
          end
          else if (!hold_reg)
            state_next = SW_SWITCH;
        end
        SW_SWITCH:
        begin
          if (!mismatch)
          begin
            nsr_next = 1'b0;
            state_next = SW_IDLE;
          end
          else if (at_boundary)
          begin
            cur_src_next = req_src;
            cur_div_next = requested_divider_sel;
            nsr_next = 1'b0;
            restart = 1'b1;
            state_next = SW_IDLE;
          end
        end
        default: state_next = SW_IDLE;
      endcase
    end
    // A software write lands after the hardware clear, so a set in the same cycle wins.
    if (ctrl_write)
    begin
      hold_next = writedata[`OSC_CTRL_HOLD_BIT];
      power_next = writedata[`OSC_CTRL_POWER_BIT];
      bypass_next = writedata[`OSC_CTRL_BYPASS_BIT];
    end
    drive_next.ext_mode = ext_osc_mode_fuse;
    drive_next.ext_enable = uses_ext(cur_src_reg) || uses_ext(req_src);
    drive_next.sec_crystal_en = !bypass_reg;
    drive_next.sec_schmitt_en = bypass_reg;
    drive_next.sec_high_power = !bypass_reg && power_reg;
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      state_reg <= SW_IDLE;
      cur_src_reg <= `OSC_RST_SRC;
      cur_div_reg <= `OSC_RST_DIV;
      nsr_reg <= ctrl_rst_value[`OSC_CTRL_NSR_BIT];
      hold_reg <= ctrl_rst_value[`OSC_CTRL_HOLD_BIT];
      power_reg <= ctrl_rst_value[`OSC_CTRL_POWER_BIT];
      bypass_reg <= ctrl_rst_value[`OSC_CTRL_BYPASS_BIT];
      init_reg <= 1'b1;
      irq_reg <= 1'b0;
      drive_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      cur_src_reg <= cur_src_next;
      cur_div_reg <= cur_div_next;
      nsr_reg <= nsr_next;
      hold_reg <= hold_next;
      power_reg <= power_next;
      bypass_reg <= bypass_next;
      init_reg <= 1'b0;
      irq_reg <= irq_next;
      drive_reg <= drive_next;
    end
  end

  assign switch_done = (state_reg == SW_IDLE) && !mismatch && !init_reg;
  assign new_source_ready = nsr_reg;
  assign switch_irq_flag = irq_reg;
  assign switch_irq = irq_reg && switch_irq_enable;
  assign current_source_sel = cur_src_reg;
  assign current_divider_sel = cur_div_reg;
  assign osc_drive = drive_reg;

  // ==========================================================================
  // System clock divider on the active source
  clock_divider u_divider (
    .clk_sys(clk_sys),
    .reset(reset),
    .src_tick(src_tick[cur_src_reg]),
    .ratio_code(cur_div_reg),
    .restart(restart),
    .out_tick(sys_clk_tick),
    .at_boundary(at_boundary)
  );

  // ==========================================================================
  // Checks
  a_reserved_bits_zero: assert property (@(posedge clk_sys) disable iff (reset)
    (read && !waitrequest) |-> (readdata[31:8] == 24'h000000)
      && ((address != `OSC_OFS_CURRENT_SEL) || !readdata[7])
      && ((address != `OSC_OFS_SWITCH_CTRL) || (readdata[2:0] == 3'h0))
      && ((address != `OSC_OFS_READY_STAT) || (!readdata[5] && !readdata[1])))
    else $error("Reserved register bit read as one.");

  a_done_means_equal: assert property (@(posedge clk_sys) disable iff (reset)
    switch_done |-> (cur_src_reg == req_src) && (cur_div_reg == requested_divider_sel))
    else $error("Switch done while current differs from request.");

  a_irq_with_ready: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(nsr_reg) |-> irq_reg)
    else $error("Interrupt flag did not set with new source ready.");

  a_hold_freezes: assert property (@(posedge clk_sys) disable iff (reset)
    (state_reg == SW_HELD && hold_reg && mismatch) |=> $stable(cur_src_reg) && $stable(cur_div_reg))
    else $error("Current selection changed while held.");

  a_switch_updates: assert property (@(posedge clk_sys) disable iff (reset)
    (state_reg == SW_SWITCH && mismatch && at_boundary && !init_reg)
      |=> (cur_src_reg == $past(req_src)) && !nsr_reg && (state_reg == SW_IDLE))
    else $error("Switch did not update current fields.");

  a_no_hold_proceeds: assert property (@(posedge clk_sys) disable iff (reset)
    ($rose(nsr_reg) && ($past(state_reg) == SW_WAIT_READY) && !$past(hold_reg)) |-> state_reg == SW_SWITCH)
    else $error("Switch did not proceed with hold clear.");

  a_reserved_to_fast: assert property (@(posedge clk_sys) disable iff (reset)
    (switch_done && is_reserved_src(requested_source_sel)) |-> cur_src_reg == `OSC_SRC_FAST)
    else $error("Reserved source code not mapped to fast internal.");

  a_bypass_drive: assert property (@(posedge clk_sys) disable iff (reset)
    ##1 $past(bypass_reg) |-> osc_drive.sec_schmitt_en && !osc_drive.sec_crystal_en && !osc_drive.sec_high_power)
    else $error("Bypass drive settings wrong.");

  a_pll_gated: assert property (@(posedge clk_sys) disable iff (reset)
    pll_locked |-> osc_ready.pll_enable && osc_ready.pll_lock)
    else $error("Multiplier locked without PLL enabled and locked.");

  a_reset_load: assert property (@(posedge clk_sys) disable iff (reset)
    init_reg |=> (cur_src_reg == $past(req_src)) && (cur_div_reg == $past(requested_divider_sel)))
    else $error("Current selection not loaded from request after reset.");

  a_wait_one_cycle: assert property (@(posedge clk_sys) disable iff (reset)
    ((read || write) && waitrequest) |=> !waitrequest)
    else $error("Waitrequest held longer than one cycle.");

endmodule : oscillator_switch_status

// ===== logic/osc_switch_map.svh
`ifndef OSC_SWITCH_MAP_SVH
`define OSC_SWITCH_MAP_SVH

// ==========================================================================
// Register byte offsets on the Avalon-MM slave
`define OSC_OFS_CURRENT_SEL 4'h0
`define OSC_OFS_SWITCH_CTRL 4'h4
`define OSC_OFS_READY_STAT 4'h8

// ==========================================================================
// Field positions of the switch control register
`define OSC_CTRL_HOLD_BIT 7
`define OSC_CTRL_POWER_BIT 6
`define OSC_CTRL_BYPASS_BIT 5
`define OSC_CTRL_DONE_BIT 4
`define OSC_CTRL_NSR_BIT 3

// ==========================================================================
// Field positions of the ready status register
`define OSC_STAT_EXT_BIT 7
`define OSC_STAT_FAST_BIT 6
`define OSC_STAT_SLOW_BIT 4
`define OSC_STAT_SEC_BIT 3
`define OSC_STAT_CONV_BIT 2
`define OSC_STAT_PLL_BIT 0

// ==========================================================================
// Source codes
`define OSC_SRC_EXT 3'h7
`define OSC_SRC_FAST 3'h6
`define OSC_SRC_RSVD_HI 3'h5
`define OSC_SRC_SLOW 3'h4
`define OSC_SRC_SEC 3'h3
`define OSC_SRC_RSVD_LO 3'h2
`define OSC_SRC_EXT_PLL 3'h1
`define OSC_SRC_FAST_PLL 3'h0

// ==========================================================================
// Divider codes and reset values
`define OSC_DIV_MAX_CODE 4'h9
`define OSC_DIV_CNT_ONE 9'h001
`define OSC_RST_SRC 3'h6
`define OSC_RST_DIV 4'h0
`define OSC_RST_CTRL 8'h00

`endif

// ===== logic/osc_switch_pkg.sv
package osc_switch_pkg;

  typedef enum logic [1:0] {SW_IDLE, SW_WAIT_READY, SW_HELD, SW_SWITCH} sw_state_t;

  typedef struct packed {
    logic ext;
    logic fast;
    logic slow;
    logic secondary;
    logic converter_rc;
    logic pll_lock;
    logic pll_enable;
  } osc_ready_t;

  typedef struct packed {
    logic [2:0] ext_mode;
    logic ext_enable;
    logic sec_crystal_en;
    logic sec_schmitt_en;
    logic sec_high_power;
  } osc_drive_t;

endpackage : osc_switch_pkg

// ===== logic/clock_divider.sv
`timescale 1ns/10ps
`include "osc_switch_map.svh"

module clock_divider
  import osc_switch_pkg::*;
(
  input wire logic clk_sys, // System clock.
  input wire logic reset, // Asynchronous reset, active high.
  input wire logic src_tick, // One tick per selected source period.
  input wire logic [3:0] ratio_code, // Divider code, two to the power n.
  input wire logic restart, // Restart the count on a new source.
  output logic out_tick, // One pulse per divided period.
  output logic at_boundary // Count sits at a period boundary.
);

  logic [8:0] count_reg;
  logic [8:0] count_next;
  logic tick_reg;
  logic tick_next;
  logic [8:0] terminal;

  // ==========================================================================
  // Divide counter
  always_comb
  begin
    // Reserved codes fall back to a ratio of one rather than an odd count.
    if (ratio_code > `OSC_DIV_MAX_CODE)
      terminal = 9'h000;
    else
      terminal = (`OSC_DIV_CNT_ONE << ratio_code) - `OSC_DIV_CNT_ONE;
    count_next = count_reg;
    tick_next = 1'b0;
    if (restart)
      count_next = 9'h000;
    else if (src_tick)
    begin
      if (count_reg >= terminal)
      begin
        count_next = 9'h000;
        tick_next = 1'b1;
      end
      else
        count_next = count_reg + `OSC_DIV_CNT_ONE;
    end
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      count_reg <= 9'h000;
      tick_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      tick_reg <= tick_next;
    end
  end

  assign out_tick = tick_reg;
  assign at_boundary = (count_reg == 9'h000);

endmodule : clock_divider

// ===== dv/test_oscillator_switch_status.sv
`timescale 1ns/10ps
`include "osc_switch_map.svh"

module test_oscillator_switch_status
  import osc_switch_pkg::*;
;
  logic clk_sys, reset, read, write, switch_irq_enable, waitrequest;
  logic switch_done, new_source_ready, switch_irq_flag, switch_irq, sys_clk_tick;
  logic [3:0] address, byteenable, requested_divider_sel, current_divider_sel;
  logic [31:0] writedata, readdata;
  logic [2:0] requested_source_sel, ext_osc_mode_fuse, current_source_sel;
  logic [7:0] src_tick;
  osc_ready_t osc_ready;
  osc_drive_t osc_drive;
  int failures, compares, cycles;
  logic [2:0] srcs [6] = '{3'h7, 3'h6, 3'h3, 3'h1, 3'h0, 3'h4};

  oscillator_switch_status oscillator_switch_status_i (
    .clk_sys(clk_sys), .reset(reset), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .requested_source_sel(requested_source_sel), .requested_divider_sel(requested_divider_sel),
    .osc_ready(osc_ready), .src_tick(src_tick), .ext_osc_mode_fuse(ext_osc_mode_fuse),
    .switch_irq_enable(switch_irq_enable), .osc_drive(osc_drive), .current_source_sel(current_source_sel),
    .current_divider_sel(current_divider_sel), .switch_done(switch_done), .new_source_ready(new_source_ready),
    .switch_irq_flag(switch_irq_flag), .switch_irq(switch_irq), .sys_clk_tick(sys_clk_tick)
  );

  // ==========================================================================
  // Clock and hang guard
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // The longest path is the divide-by-512 measurement; the ceiling leaves ample room.
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      end_of_test();
    end
  end

  // ==========================================================================
  // Bus and check tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  // Waitrequest is sampled at the rising edge; data is taken and the request dropped only at that edge.
  task bus_rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    address <= a;
    read <= 1'b1;
    do @(posedge clk_sys); while (waitrequest !== 1'b0);
    chk(readdata, exp);
    read <= 1'b0;
  endtask : bus_rd

  task wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
    @(posedge clk_sys);
    address <= a;
    writedata <= {24'h0, d};
    byteenable <= be;
    write <= 1'b1;
    do @(posedge clk_sys); while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask : wr

  task wait_nsr;
    while (new_source_ready !== 1'b1) @(negedge clk_sys);
    chk(32'(switch_irq_flag), 32'h1);
    chk(32'(switch_irq), 32'(switch_irq_enable));
  endtask : wait_nsr

  task switch_to(input logic [2:0] s, input logic [3:0] d, input logic [2:0] eff);
    @(posedge clk_sys);
    requested_source_sel <= s;
    requested_divider_sel <= d;
    @(negedge clk_sys);
    wait_nsr();
    while (switch_done !== 1'b1) @(negedge clk_sys);
    chk(32'({current_source_sel, current_divider_sel}), 32'({eff, d}));
    chk(32'(new_source_ready), 32'h0);
  endtask : switch_to

  task end_of_test;
    if (failures == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  // ==========================================================================
  // Main sequence
  initial
  begin
    int cnt;
    reset = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 4'h0;
    byteenable = 4'hF;
    writedata = 32'h0;
    requested_source_sel = 3'h4;
    requested_divider_sel = 4'h3;
    osc_ready = 7'h7F;
    src_tick = 8'hFF;
    ext_osc_mode_fuse = 3'h5;
    switch_irq_enable = 1'b1;
    failures = 0;
    compares = 0;
    cycles = 0;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    bus_rd(`OSC_OFS_CURRENT_SEL, 32'h43);
    bus_rd(`OSC_OFS_SWITCH_CTRL, 32'h10);
    wr(4'hC, 8'hFF, 4'hF);
    bus_rd(4'hC, 32'h0);
    @(posedge clk_sys);
    osc_ready <= 7'b1101011;
    bus_rd(`OSC_OFS_READY_STAT, 32'hC9);
    // The PLL is locked and enabled but its input source is not ready.
    osc_ready <= 7'b0010111;
    bus_rd(`OSC_OFS_READY_STAT, 32'h14);
    osc_ready <= 7'h7F;
    // A write without the low byte lane must leave the control bits alone.
    wr(`OSC_OFS_SWITCH_CTRL, 8'hE0, 4'hE);
    bus_rd(`OSC_OFS_SWITCH_CTRL, 32'h10);
    wr(`OSC_OFS_SWITCH_CTRL, 8'hE7, 4'hF);
    bus_rd(`OSC_OFS_SWITCH_CTRL, 32'hF0);
    chk(32'({osc_drive.sec_crystal_en, osc_drive.sec_schmitt_en}), 32'h1);
    wr(`OSC_OFS_SWITCH_CTRL, 8'h40, 4'hF);
    bus_rd(`OSC_OFS_SWITCH_CTRL, 32'h50);
    chk(32'({osc_drive.sec_crystal_en, osc_drive.sec_schmitt_en, osc_drive.sec_high_power}), 32'h5);
    wr(`OSC_OFS_SWITCH_CTRL, 8'h00, 4'hF);
    bus_rd(`OSC_OFS_SWITCH_CTRL, 32'h10);
    chk(32'({osc_drive.sec_crystal_en, osc_drive.sec_schmitt_en, osc_drive.sec_high_power}), 32'h4);
    foreach (srcs[i])
    begin
      switch_to(srcs[i], 4'h0, srcs[i]);
      if (srcs[i] == 3'h7 || srcs[i] == 3'h1)
        chk(32'({osc_drive.ext_mode, osc_drive.ext_enable}), 32'({ext_osc_mode_fuse, 1'b1}));
    end
    switch_to(3'h5, 4'h1, 3'h6);
    switch_to(3'h2, 4'h2, 3'h6);
    for (int n = 0; n <= 9; n++)
    begin
      @(posedge clk_sys);
      switch_irq_enable <= n[0];
      switch_to(3'h6, 4'(n), 3'h6);
      while (sys_clk_tick !== 1'b1) @(negedge clk_sys);
      cnt = 0;
      do
      begin
        @(negedge clk_sys);
        cnt++;
      end
      while (sys_clk_tick !== 1'b1);
      chk(32'(cnt), 32'h1 << n);
    end
    // Held switch: the new source is ready but the clock must stay on the old one.
    wr(`OSC_OFS_SWITCH_CTRL, 8'h80, 4'hF);
    @(posedge clk_sys);
    requested_source_sel <= 3'h4;
    @(negedge clk_sys);
    wait_nsr();
    repeat (20) @(negedge clk_sys);
    chk(32'({switch_done, current_source_sel}), 32'h6);
    bus_rd(`OSC_OFS_SWITCH_CTRL, 32'h88);
    wr(`OSC_OFS_SWITCH_CTRL, 8'h00, 4'hF);
    while (switch_done !== 1'b1) @(negedge clk_sys);
    chk(32'({current_source_sel, current_divider_sel}), 32'h49);
    // Abandoned switch: copying the current source back clears the hold by hardware.
    wr(`OSC_OFS_SWITCH_CTRL, 8'h80, 4'hF);
    @(posedge clk_sys);
    requested_source_sel <= 3'h7;
    @(negedge clk_sys);
    wait_nsr();
    @(posedge clk_sys);
    requested_source_sel <= 3'h4;
    repeat (3) @(posedge clk_sys);
    bus_rd(`OSC_OFS_SWITCH_CTRL, 32'h10);
    chk(32'(current_source_sel), 32'h4);
    @(posedge clk_sys);
    requested_source_sel <= 3'h5;
    requested_divider_sel <= 4'h1;
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    bus_rd(`OSC_OFS_CURRENT_SEL, 32'h61);
    end_of_test();
  end
endmodule : test_oscillator_switch_status
